// File: design/rcs_pkg.sv
package rcs_pkg;

    // opcode upper seven bits; bit 0 is the size bit
    localparam logic [6:0] OPC_IMM_COUNT = 7'h60;
    localparam logic [6:0] OPC_BY_ONE = 7'h68;
    localparam logic [6:0] OPC_BY_CL = 7'h69;

    // second byte fields, plus the opcode size bit position
    localparam int MODRM_MOD_HI = 7;
    localparam int MODRM_MOD_LO = 6;
    localparam int MODRM_SUB_HI = 5;
    localparam int MODRM_SUB_LO = 3;
    localparam int MODRM_RM_HI = 2;
    localparam int OPC_SIZE_BIT = 0;
    localparam logic [2:0] SUB_ROTATE_RIGHT = 3'h1;
    localparam logic [2:0] SUB_ROTATE_LEFT_CARRY = 3'h2;
    localparam logic [1:0] MOD_NO_DISP = 2'h0;
    localparam logic [1:0] MOD_DISP8 = 2'h1;
    localparam logic [1:0] MOD_DISP16 = 2'h2;
    localparam logic [1:0] MOD_REGISTER = 2'h3;
    localparam logic [2:0] RM_DIRECT = 3'h6;

    // instruction length pieces, in bytes
    localparam logic [2:0] LEN_BASE = 3'h2;
    localparam logic [2:0] LEN_IMM = 3'h1;
    localparam logic [2:0] LEN_DISP8 = 3'h1;
    localparam logic [2:0] LEN_DISP16 = 3'h2;

    // execution clocks, processor clocks, before adding the shift count
    localparam logic [8:0] CLK_REG_MULTI = 9'h007;
    localparam logic [8:0] CLK_MEM_MULTI_SHORT = 9'h013;
    localparam logic [8:0] CLK_MEM_MULTI_LONG = 9'h01B;
    // single-bit totals include their one shift
    localparam logic [8:0] CLK_REG_SINGLE = 9'h002;
    localparam logic [8:0] CLK_MEM_SINGLE_SHORT = 9'h010;
    localparam logic [8:0] CLK_MEM_SINGLE_LONG = 9'h018;
    localparam logic [8:0] CLK_ILLEGAL = 9'h001;
    localparam logic [7:0] COUNT_ONE = 8'h01;

    // reset values
    localparam logic [15:0] RESET_VALUE = 16'h0000;

    typedef enum logic [1:0] {
        RCS_IDLE = 2'b01,
        RCS_RUN = 2'b10
    } rcs_state_t;

endpackage

// File: design/rcs_step.sv
`timescale 1ns/1ps
`default_nettype none
module rcs_step (
    input wire logic [15:0] value,
    input wire logic carry,
    input wire logic word,
    input wire logic left_thru_carry,
    output logic [15:0] next_value,
    output logic next_carry
);
    wire logic msb;
    wire logic [15:0] ror_word;
    wire logic [15:0] ror_byte;
    wire logic [15:0] rotate_left_thru_carry_op_word;
    wire logic [15:0] rotate_left_thru_carry_op_byte;

    assign msb = word ? value[15] : value[7];
    // byte forms leave the upper byte untouched
    assign ror_word = {value[0], value[15:1]};
    assign ror_byte = {value[15:8], value[0], value[7:1]};
    assign rotate_left_thru_carry_op_word = {value[14:0], carry};
    assign rotate_left_thru_carry_op_byte = {value[15:8], value[6:0], carry};
    assign next_value = left_thru_carry ? (word ? rotate_left_thru_carry_op_word : rotate_left_thru_carry_op_byte)
                                        : (word ? ror_word : ror_byte);
    assign next_carry = left_thru_carry ? msb : value[0];
endmodule // rcs_step
`default_nettype wire

// File: design/rcs_rotate_unit.sv
`timescale 1ns/1ps
`default_nettype none
module rcs_rotate_unit (
    input wire logic clk,
    input wire logic reset,
    input wire logic start,
    input wire logic [7:0] opcode_byte,
    input wire logic [7:0] modrm_byte,
    input wire logic [7:0] immediate_count_byte,
    input wire logic [7:0] shift_count_register,
    input wire logic [15:0] operand,
    input wire logic carry_flag_in,
    input wire logic overflow_flag_in,
    input wire logic bus_is_8bit,
    input wire logic address_odd,
    output logic busy_q,
    output logic done_q,
    output logic illegal_q,
    output logic [15:0] result_q,
    output logic carry_flag_q,
    output logic overflow_flag_q,
    output logic overflow_defined_q,
    output logic [2:0] length_q
);
////////////////////////////////////////////////////////////////////////////
    // decode
    wire logic [6:0] op_hi;
    wire logic [1:0] mod_f;
    wire logic [2:0] sub_f;
    wire logic [2:0] rm_f;
    wire logic is_imm_op;
    wire logic is_one_op;
    wire logic is_cl_op;
    wire logic rotate_right_op;
    wire logic rotate_left_thru_carry_op;
    wire logic supported;
    wire logic is_reg;
    wire logic word;
    wire logic long_mem;
    wire logic [2:0] disp_len;
    wire logic [2:0] length_d;
    wire logic [7:0] count_d;
    wire logic [8:0] base_d;
    wire logic [8:0] total_d;
    wire logic accept;
    wire logic ovf_defined_d;

    localparam int MODRM_MOD_HI_C = rcs_pkg::MODRM_MOD_HI;
    localparam int MODRM_MOD_LO_C = rcs_pkg::MODRM_MOD_LO;
    localparam int MODRM_SUB_HI_C = rcs_pkg::MODRM_SUB_HI;
    localparam int MODRM_SUB_LO_C = rcs_pkg::MODRM_SUB_LO;
    localparam int MODRM_RM_HI_C = rcs_pkg::MODRM_RM_HI;

    assign op_hi = opcode_byte[7:1];
    assign mod_f = modrm_byte[MODRM_MOD_HI_C:MODRM_MOD_LO_C];
    assign sub_f = modrm_byte[MODRM_SUB_HI_C:MODRM_SUB_LO_C];
    assign rm_f = modrm_byte[MODRM_RM_HI_C:0];
    assign is_imm_op = op_hi == rcs_pkg::OPC_IMM_COUNT;
    assign is_one_op = op_hi == rcs_pkg::OPC_BY_ONE;
    assign is_cl_op = op_hi == rcs_pkg::OPC_BY_CL;
    assign rotate_right_op = sub_f == rcs_pkg::SUB_ROTATE_RIGHT;
    assign rotate_left_thru_carry_op =
        sub_f == rcs_pkg::SUB_ROTATE_LEFT_CARRY;
    assign supported = (is_imm_op && (rotate_right_op ||
                        rotate_left_thru_carry_op)) ||
                       ((is_one_op || is_cl_op) && rotate_left_thru_carry_op);
    assign is_reg = mod_f == rcs_pkg::MOD_REGISTER;
    assign word = opcode_byte[rcs_pkg::OPC_SIZE_BIT];
    assign long_mem = word && (bus_is_8bit || address_odd);

    // displacement bytes from the addressing mode
    assign disp_len =
        (mod_f == rcs_pkg::MOD_DISP8) ? rcs_pkg::LEN_DISP8 :
        (mod_f == rcs_pkg::MOD_DISP16) ? rcs_pkg::LEN_DISP16 :
        (mod_f == rcs_pkg::MOD_NO_DISP && rm_f == rcs_pkg::RM_DIRECT) ?
            rcs_pkg::LEN_DISP16 : 3'h0;
    assign length_d = rcs_pkg::LEN_BASE + disp_len +
                      (is_imm_op ? rcs_pkg::LEN_IMM : 3'h0);

    // count source, never masked
    assign count_d = is_imm_op ? immediate_count_byte :
                     is_cl_op ? shift_count_register :
                     rcs_pkg::COUNT_ONE;

    // fixed part of execution time; single-bit totals hold their shift
    assign base_d =
        is_one_op ? (is_reg ? rcs_pkg::CLK_REG_SINGLE - 9'h001 :
                     long_mem ? rcs_pkg::CLK_MEM_SINGLE_LONG - 9'h001 :
                     rcs_pkg::CLK_MEM_SINGLE_SHORT - 9'h001) :
        is_reg ? rcs_pkg::CLK_REG_MULTI :
        long_mem ? rcs_pkg::CLK_MEM_MULTI_LONG :
        rcs_pkg::CLK_MEM_MULTI_SHORT;
    assign total_d = supported ? base_d + {1'b0, count_d} :
                     rcs_pkg::CLK_ILLEGAL;

    // overflow defined for single-bit, and for memory by count register
    assign ovf_defined_d = supported &&
        (is_one_op || (is_cl_op && !is_reg));
    assign accept = start && !busy_q;

////////////////////////////////////////////////////////////////////////////
    // sequencing
    rcs_pkg::rcs_state_t state_q;
    rcs_pkg::rcs_state_t state_d;
    logic [8:0] remain_q;
    logic [7:0] cnt_q;
    logic word_q;
    logic left_q;
    logic ovf_def_q;
    wire logic running;
    wire logic last;
    wire logic stepping;
    wire logic [15:0] step_value;
    wire logic step_carry;
    wire logic final_msb;

    assign running = state_q == rcs_pkg::RCS_RUN;
    assign last = running && remain_q == 9'h001;
    assign stepping = running && cnt_q != 8'h00;
    assign final_msb = word_q ? result_q[15] : result_q[7];
    assign state_d = accept ? rcs_pkg::RCS_RUN :
                     last ? rcs_pkg::RCS_IDLE : state_q;

    rcs_step u_step (
        .value(result_q),
        .carry(carry_flag_q),
        .word(word_q),
        .left_thru_carry(left_q),
        .next_value(step_value),
        .next_carry(step_carry)
    );

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= rcs_pkg::RCS_IDLE;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            busy_q <= state_d == rcs_pkg::RCS_RUN;
            done_q <= last;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            remain_q <= 9'h000;
            cnt_q <= 8'h00;
        end else if (accept) begin
            remain_q <= total_d;
            cnt_q <= supported ? count_d : 8'h00;
        end else if (running) begin
            remain_q <= remain_q - 9'h001;
            cnt_q <= stepping ? cnt_q - 8'h01 : cnt_q;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            word_q <= 1'b0;
            left_q <= 1'b0;
            ovf_def_q <= 1'b0;
            illegal_q <= 1'b0;
            length_q <= 3'h0;
        end else if (accept) begin
            word_q <= word;
            left_q <= rotate_left_thru_carry_op;
            ovf_def_q <= ovf_defined_d;
            illegal_q <= !supported;
            length_q <= length_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            result_q <= rcs_pkg::RESET_VALUE;
            carry_flag_q <= 1'b0;
        end else if (accept) begin
            result_q <= operand;
            carry_flag_q <= carry_flag_in;
        end else if (stepping) begin
            result_q <= step_value;
            carry_flag_q <= step_carry;
        end
    end

    // undefined overflow passes through unchanged
    always_ff @(posedge clk) begin
        if (reset) begin
            overflow_flag_q <= 1'b0;
            overflow_defined_q <= 1'b0;
        end else if (accept) begin
            overflow_flag_q <= overflow_flag_in;
            overflow_defined_q <= 1'b0;
        end else if (last) begin
            overflow_flag_q <= ovf_def_q ? final_msb ^ carry_flag_q
                                         : overflow_flag_q;
            overflow_defined_q <= ovf_def_q;
        end
    end

////////////////////////////////////////////////////////////////////////////
    // checks
    logic [8:0] elapsed_q;
    logic [8:0] expect_q;
    logic reg_multi_q;

    // register multibit time rebuilt from the fixed cost, not total_d
    always_ff @(posedge clk) begin
        if (reset) begin
            elapsed_q <= 9'h000;
            expect_q <= 9'h000;
            reg_multi_q <= 1'b0;
        end else if (accept) begin
            elapsed_q <= 9'h001;
            expect_q <= rcs_pkg::CLK_REG_MULTI + {1'b0, count_d};
            reg_multi_q <= supported && is_reg && !is_one_op;
        end else if (running) begin
            elapsed_q <= elapsed_q + 9'h001;
        end
    end

    a_ror_step_bits: assert property (
        @(posedge clk) disable iff (reset)
        stepping && !left_q && !word_q |=>
            result_q[7] == $past(result_q[0]) &&
            carry_flag_q == $past(result_q[0]) &&
            result_q[6:0] == $past(result_q[7:1]))
        else $error("right rotate step wrong");

    a_rotate_left_thru_carry_op_step_ring: assert property (
        @(posedge clk) disable iff (reset)
        stepping && left_q && word_q |=>
            carry_flag_q == $past(result_q[15]) &&
            result_q[0] == $past(carry_flag_q) &&
            result_q[15:1] == $past(result_q[14:0]))
        else $error("left carry rotate step wrong");

    a_zero_count_keep: assert property (
        @(posedge clk) disable iff (reset)
        accept && supported && is_imm_op && is_reg &&
        immediate_count_byte == 8'h00 |->
            ##8 done_q && result_q == $past(operand, 8))
        else $error("zero count changed operand or time");

    a_reg_multi_time: assert property (
        @(posedge clk) disable iff (reset)
        last && reg_multi_q |->
            elapsed_q == expect_q)
        else $error("execution time mismatch");

    a_single_reg_time: assert property (
        @(posedge clk) disable iff (reset)
        accept && is_one_op && rotate_left_thru_carry_op && is_reg |->
            ##3 done_q && length_q == 3'h2)
        else $error("single register rotate not two clocks");

    a_single_mem_time: assert property (
        @(posedge clk) disable iff (reset)
        accept && is_one_op && rotate_left_thru_carry_op && !is_reg &&
        !word |-> ##17 done_q)
        else $error("single memory byte rotate not 16 clocks");

    a_mem_multi_time: assert property (
        @(posedge clk) disable iff (reset)
        accept && supported && !is_one_op && !is_reg && long_mem &&
        count_d == 8'h02 |-> ##30 done_q)
        else $error("long memory multibit time wrong");

    a_ovf_single: assert property (
        @(posedge clk) disable iff (reset)
        done_q && overflow_defined_q |->
            overflow_flag_q == ((word_q ? result_q[15] : result_q[7]) ^
                                carry_flag_q))
        else $error("overflow not msb xor carry");

    a_len_imm_reg: assert property (
        @(posedge clk) disable iff (reset)
        accept && supported && is_imm_op && is_reg |=> length_q == 3'h3)
        else $error("immediate register form not three bytes");

    a_len_mem_range: assert property (
        @(posedge clk) disable iff (reset)
        accept && supported && !is_reg |=>
            length_q >= 3'h2 && length_q <= 3'h5)
        else $error("memory form length out of range");

    a_cl_reg_len: assert property (
        @(posedge clk) disable iff (reset)
        accept && is_cl_op && rotate_left_thru_carry_op && is_reg |=>
            length_q == 3'h2 && !overflow_defined_q)
        else $error("count register form length wrong");

    a_full_count: assert property (
        @(posedge clk) disable iff (reset)
        accept && supported && count_d == 8'hFF |=> cnt_q == 8'hFF)
        else $error("count was masked");

endmodule // rcs_rotate_unit
`default_nettype wire

// File: verification/tb_rotate_carry_shift_unit.sv
`timescale 1ns/1ps
`default_nettype none
module tb_rotate_carry_shift_unit;

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic start = 1'b0;
    logic [7:0] opcode_byte = 8'h00;
    logic [7:0] modrm_byte = 8'h00;
    logic [7:0] immediate_count_byte = 8'h00;
    logic [7:0] shift_count_register = 8'h00;
    logic [15:0] operand = 16'h0000;
    logic carry_flag_in = 1'b0;
    logic overflow_flag_in = 1'b0;
    logic bus_is_8bit = 1'b0;
    logic address_odd = 1'b0;
    logic busy_q;
    logic done_q;
    logic illegal_q;
    logic [15:0] result_q;
    logic carry_flag_q;
    logic overflow_flag_q;
    logic overflow_defined_q;
    logic [2:0] length_q;
    integer bad_count = 0;
    integer n_checks = 0;
    integer cycles = 0;
    integer seed = 88;
    logic [31:0] r;
    logic [7:0] opc;
    logic [7:0] mrm;

    rcs_rotate_unit rcs_rotate_unit_i (
        .clk(clk), .reset(reset), .start(start),
        .opcode_byte(opcode_byte), .modrm_byte(modrm_byte),
        .immediate_count_byte(immediate_count_byte),
        .shift_count_register(shift_count_register),
        .operand(operand), .carry_flag_in(carry_flag_in),
        .overflow_flag_in(overflow_flag_in), .bus_is_8bit(bus_is_8bit),
        .address_odd(address_odd), .busy_q(busy_q), .done_q(done_q),
        .illegal_q(illegal_q), .result_q(result_q),
        .carry_flag_q(carry_flag_q), .overflow_flag_q(overflow_flag_q),
        .overflow_defined_q(overflow_defined_q), .length_q(length_q)
    );

    always #2 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task close_out;
        if (bad_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // hang guard, longest run is well below this
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles >= 60000) begin
            bad_count = bad_count + 1;
            close_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // start held high while busy; operand scrambled to prove it is ignored
    task automatic run_op(input logic [7:0] op, input logic [7:0] md,
            input logic [7:0] imm, input logic [7:0] cl,
            input logic [15:0] opd, input logic ci, input logic vi,
            input logic b8, input logic odd);
        int n;
        int t;
        int cnt;
        int len;
        logic [6:0] o7;
        logic w;
        logic mem;
        logic ill;
        logic top;
        logic c;
        logic od;
        logic ov;
        logic lng;
        logic [15:0] v;
        o7 = op[7:1];
        w = op[0];
        mem = md[7:6] != 2'h3;
        lng = w && (b8 || odd);
        ill = !((o7 == 7'h60 && (md[5:3] == 3'h1 || md[5:3] == 3'h2)) ||
            ((o7 == 7'h68 || o7 == 7'h69) && md[5:3] == 3'h2));
        n = (o7 == 7'h60) ? imm : ((o7 == 7'h68) ? 1 : cl);
        if (ill) n = 0;
        v = opd;
        c = ci;
        for (int i = 0; i < n; i++) begin
            if (md[5:3] == 3'h1) begin
                top = v[0];
                if (w) v = {top, v[15:1]};
                else v = {v[15:8], top, v[7:1]};
            end else begin
                top = w ? v[15] : v[7];
                if (w) v = {v[14:0], c};
                else v = {v[15:8], v[6:0], c};
            end
            c = top;
        end
        od = !ill && (o7 == 7'h68 || (o7 == 7'h69 && mem));
        ov = od ? ((w ? v[15] : v[7]) ^ c) : vi;
        if (ill) t = 1;
        else if (o7 == 7'h68) t = mem ? (lng ? 24 : 16) : 2;
        else t = mem ? ((lng ? 27 : 19) + n) : 7 + n;
        len = 2 + ((o7 == 7'h60) ? 1 : 0);
        if (md[7:6] == 2'h1) len = len + 1;
        if (md[7:6] == 2'h2 || (md[7:6] == 2'h0 && md[2:0] == 3'h6))
            len = len + 2;
        @(posedge clk);
        opcode_byte <= op;
        modrm_byte <= md;
        immediate_count_byte <= imm;
        shift_count_register <= cl;
        operand <= opd;
        carry_flag_in <= ci;
        overflow_flag_in <= vi;
        bus_is_8bit <= b8;
        address_odd <= odd;
        start <= 1'b1;
        @(posedge clk);
        operand <= ~opd;
        cnt = 0;
        do begin
            @(posedge clk);
            cnt = cnt + 1;
            if (cnt >= t) start <= 1'b0;
            #1;
            if (done_q !== 1'b1) check({31'h0, busy_q}, 32'h1);
        end while (done_q !== 1'b1 && cnt < 300);
        check(cnt, t);
        check({31'h0, busy_q}, 32'h0);
        check({31'h0, illegal_q}, {31'h0, ill});
        check({16'h0, result_q}, {16'h0, v});
        check({31'h0, carry_flag_q}, {31'h0, c});
        check({31'h0, overflow_defined_q}, {31'h0, od});
        check({31'h0, overflow_flag_q}, {31'h0, ov});
        if (!ill) check({29'h0, length_q}, len);
        @(posedge clk);
        #1;
        check({31'h0, done_q}, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        check({busy_q, done_q, illegal_q, result_q}, 32'h0);
        check({carry_flag_q, overflow_flag_q, length_q}, 32'h0);
        // zero count, then full count
        run_op(8'hC1, 8'hC8, 8'h00, 8'h00, 16'h8001, 1'b1, 1'b1, 1'b0,
            1'b0);
        run_op(8'hC1, 8'hD3, 8'hFF, 8'h00, 16'h1234, 1'b1, 1'b0, 1'b0,
            1'b0);
        // single-bit, both overflow outcomes
        run_op(8'hD0, 8'hD1, 8'h00, 8'h00, 16'h0040, 1'b0, 1'b0, 1'b0,
            1'b0);
        run_op(8'hD0, 8'hD1, 8'h00, 8'h00, 16'h00C0, 1'b0, 1'b0, 1'b0,
            1'b0);
        run_op(8'hD1, 8'h96, 8'h00, 8'h00, 16'h8000, 1'b1, 1'b0, 1'b0,
            1'b1);
        run_op(8'hD3, 8'h16, 8'h00, 8'h02, 16'hA5A5, 1'b0, 1'b1, 1'b1,
            1'b0);
        run_op(8'hC1, 8'h4E, 8'h03, 8'h00, 16'hF00F, 1'b0, 1'b0, 1'b0,
            1'b0);
        run_op(8'h00, 8'hC0, 8'h03, 8'h00, 16'h5A5A, 1'b1, 1'b0, 1'b0,
            1'b0);
        run_op(8'hD2, 8'hD0, 8'h03, 8'h02, 16'h5A5A, 1'b0, 1'b0, 1'b0,
            1'b0);
        for (int k = 0; k < 120; k++) begin
            r = $random(seed);
            case (r[1:0])
                2'h0: opc = {7'h60, r[2]};
                2'h1: opc = {7'h68, r[2]};
                2'h2: opc = {7'h69, r[2]};
                default: opc = r[15:8];
            endcase
            mrm = r[23:16];
            if (r[4:3] != 2'h0) mrm[5:3] = r[5] ? 3'h1 : 3'h2;
            r = $random(seed);
            run_op(opc, mrm, r[7:0], r[15:8], r[31:16], r[0], r[1],
                r[2], r[3]);
        end
        close_out;
    end

endmodule // tb_rotate_carry_shift_unit
`default_nettype wire
